// ===== rail2_serial_voltage_id_bus_phase_shed_config.sv
// Rail 2 serial-VID report, phase shedding and DC loop hold register bank
//
// Contract
// R1: Reserved bits drop writes and read back as zero.
// R2: Protocol low byte gives supported serial-VID revision, codes 01h to 08h.
// R3: Capability high byte maps optional telemetry; 00h means mandatory only.
// R4: Capability low byte holds load line, 0.1 milliohm per step.
// R5: Slew register: fast rate high byte, slow rate low byte, mV/us.
// R6: Bit 9 seeds rail 1 ready policy at zero voltage target.
// R7: Bit 8 seeds rail 2 ready policy at zero voltage target.
// R8: Tolerance low byte holds rail 2 tolerance band.
// R9: Shedding settings act only while shedding mode field reads 1x.
// R10: Pair high byte: threshold to one continuous phase, 1 A steps.
// R11: Pair low byte: threshold to two continuous phases, 1 A steps.
// R12: Single low byte: threshold to discontinuous single phase, 1 A steps.
// R13: Mode bit 0 drops straight to target, 1 drops one by one.
// R14: Six-bit wait sets microseconds between single drops in one-by-one mode.
// R15: Four-bit hysteresis in amperes separates shedding from re-adding.
// R16: Droop offset is sign-magnitude, bit 5 negative, 0.81 uA per step.
// R17: Bit 15 picks low interval or direct add on period condition.
// R18: Bit 14 picks low interval or direct add on low feedback.
// R19: Hold loops while period deviation within window times 80 ns, not DISCONTINUOUS_CONDUCTION.
// R20: Three enables allow holds on frequency, phase count, window excursion.
// R21: Minimum hold is 200 us per step plus 100 us.
// R22: Exit bits 0 to 2 leave shedding on overcurrent, frequency, low feedback.
// R23: Shed below threshold, restore at threshold plus hysteresis.
`timescale 1ns/100ps
`default_nettype none
module rail2_serial_voltage_id_bus_phase_shed_config #(
    parameter int unsigned HOLD_STEP_CYCLE_COUNT = rail2_shed_pkg::HOLD_STEP_CYCLES,
    parameter int unsigned HOLD_OFFSET_CYCLE_COUNT = rail2_shed_pkg::HOLD_OFFSET_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire rail2_shed_pkg::command_type regCommand,
    input wire rail2_shed_pkg::word_type regWriteData,
    output rail2_shed_pkg::word_type regReadData,
    output logic regUnmapped,
    input wire logic [1:0] apsModeField,
    input wire logic [7:0] railCurrent,
    input wire logic overcurrentEvent,
    input wire logic frequencyLimitEvent,
    input wire logic lowFeedbackEvent,
    input wire logic [15:0] periodDeviationNs,
    input wire logic feedbackOutside,
    input wire logic periodAddRequest,
    input wire logic undervoltageAddRequest,
    input wire logic rail1VoltageZero,
    input wire logic rail2VoltageZero,
    input wire logic rail1PowerGood,
    input wire logic rail2PowerGood,
    output logic rail1ReadyOutput,
    output logic rail2ReadyOutput,
    output logic [1:0] phaseLevel,
    output logic discontinuousConduction,
    output logic phaseLevelChanged,
    output logic dcLoopHold,
    output logic addLowIntervalInsert,
    output logic droopNegative,
    output logic [4:0] droopMagnitude,
    output logic [7:0] protocolRevisionCode,
    output logic [7:0] telemetryCapability,
    output logic [7:0] loadLineValue,
    output logic [7:0] fastSlewCapability,
    output logic [7:0] slowSlewCapability,
    output logic [7:0] rail2ToleranceBand
);
    import rail2_shed_pkg::*;

    typedef struct packed {
        word_type [REG_COUNT-1:0] regs;
        word_type readData;
        logic unmapped;
        logic rail1Ready;
        logic rail2Ready;
        logic lowInsert;
        phase_level_type target;
    } bank_type;

    bank_type b_q, b_d;

    logic hit;
    logic [3:0] hitIndex;
    logic apsEnabled;
    logic shedStepMode;
    logic [5:0] dropWait;
    logic [7:0] oneThreshold;
    logic [7:0] twoThreshold;
    logic [7:0] dcmThreshold;
    logic [3:0] hysteresis;
    logic [8:0] oneRestore;
    logic [8:0] twoRestore;
    logic [8:0] dcmRestore;
    logic [8:0] currentWide;
    logic exitRequest;
    logic belowDcm;
    logic belowOne;
    logic belowTwo;
    phase_level_type seqLevel;
    logic seqChanged;

    // Command decode over the ten page-one entries
    always_comb begin
        hit = 1'b0;
        hitIndex = 4'h0;
        for (int i = 0; i < REG_COUNT; i++) begin
            if (regCommand == REG_COMMAND[i]) begin
                hit = 1'b1;
                hitIndex = 4'(i);
            end
        end
    end

    // Field views of the stored words
    always_comb begin
        apsEnabled = apsModeField[APS_ENABLE_BIT]; // R9
        shedStepMode = b_q.regs[IDX_PACING][SHED_MODE_BIT];
        dropWait = b_q.regs[IDX_PACING][DROP_WAIT_MSB:DROP_WAIT_LSB];
        hysteresis = b_q.regs[IDX_PACING][HYS_MSB:0];
        oneThreshold = b_q.regs[IDX_THRESH_PAIR][15:8]; // R10
        twoThreshold = b_q.regs[IDX_THRESH_PAIR][7:0]; // R11
        dcmThreshold = b_q.regs[IDX_THRESH_SINGLE][7:0]; // R12
        // Nine bits so threshold plus hysteresis cannot wrap past 255 A
        oneRestore = 9'(oneThreshold) + 9'(hysteresis); // R15
        twoRestore = 9'(twoThreshold) + 9'(hysteresis); // R15
        dcmRestore = 9'(dcmThreshold) + 9'(hysteresis); // R15
        currentWide = 9'(railCurrent);
        exitRequest = (b_q.regs[IDX_EXIT][EXIT_OC_BIT] && overcurrentEvent) // R22
            || (b_q.regs[IDX_EXIT][EXIT_FS_BIT] && frequencyLimitEvent) // R22
            || (b_q.regs[IDX_EXIT][EXIT_UV_BIT] && lowFeedbackEvent); // R22
    end

    // Shed when below a threshold, restore only once at or above threshold plus hysteresis
    always_comb begin
        if (seqLevel > LEVEL_DCM) begin
            belowDcm = currentWide < 9'(dcmThreshold); // R23
        end else begin
            belowDcm = currentWide < dcmRestore; // R23
        end
        if (seqLevel > LEVEL_ONE) begin
            belowOne = currentWide < 9'(oneThreshold); // R23
        end else begin
            belowOne = currentWide < oneRestore; // R23
        end
        if (seqLevel > LEVEL_TWO) begin
            belowTwo = currentWide < 9'(twoThreshold); // R23
        end else begin
            belowTwo = currentWide < twoRestore; // R23
        end
    end

    // Next state of the bank
    always_comb begin
        b_d = b_q;
        if (regWrite && hit) begin
            b_d.regs[hitIndex] = regWriteData & REG_WRITE_MASK[hitIndex]; // R1
        end
        if (regRead) begin
            // Stored words already hold zero in reserved positions
            b_d.readData = hit ? b_q.regs[hitIndex] : REG_RESET; // R1
            b_d.unmapped = !hit;
        end
        b_d.rail1Ready = rail1PowerGood
            && (!rail1VoltageZero || b_q.regs[IDX_TOLERANCE][RAIL1_READY_BIT]); // R6
        b_d.rail2Ready = rail2PowerGood
            && (!rail2VoltageZero || b_q.regs[IDX_TOLERANCE][RAIL2_READY_BIT]); // R7
        if (periodAddRequest) begin
            b_d.lowInsert = !b_q.regs[IDX_LOOP_HOLD][PERIOD_ADD_BIT]; // R17
        end else if (undervoltageAddRequest) begin
            b_d.lowInsert = !b_q.regs[IDX_LOOP_HOLD][UNDERVOLT_ADD_BIT]; // R18
        end else begin
            b_d.lowInsert = 1'b0;
        end
        // Disabled shedding or an enabled exit event runs every phase
        if (!apsEnabled || exitRequest) begin
            b_d.target = LEVEL_FULL; // R9 R22
        end else if (belowDcm) begin
            b_d.target = LEVEL_DCM;
        end else if (belowOne) begin
            b_d.target = LEVEL_ONE;
        end else if (belowTwo) begin
            b_d.target = LEVEL_TWO;
        end else begin
            b_d.target = LEVEL_FULL;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            b_q <= '{regs: '0, readData: REG_RESET, unmapped: 1'b0, rail1Ready: 1'b0,
                rail2Ready: 1'b0, lowInsert: 1'b0, target: LEVEL_FULL};
        end else begin
            b_q <= b_d;
        end
    end

    shed_phase_sequencer u_sequencer (
        .clk(clk),
        .rst(rst),
        .targetLevel(b_q.target),
        .stepMode(shedStepMode),
        .waitSteps(dropWait),
        .phaseLevel(seqLevel),
        .levelChanged(seqChanged)
    );

    dc_loop_hold #(
        .STEP_CYCLES(HOLD_STEP_CYCLE_COUNT),
        .OFFSET_CYCLES(HOLD_OFFSET_CYCLE_COUNT)
    ) u_hold (
        .clk(clk),
        .rst(rst),
        .periodDeviationNs(periodDeviationNs),
        .deviationWindow(b_q.regs[IDX_LOOP_HOLD][WINDOW_MSB:WINDOW_LSB]),
        .frequencyEnable(b_q.regs[IDX_LOOP_HOLD][FREQ_HOLD_BIT]),
        .phaseEnable(b_q.regs[IDX_LOOP_HOLD][PHASE_HOLD_BIT]),
        .windowEnable(b_q.regs[IDX_LOOP_HOLD][WINDOW_HOLD_BIT]),
        .minimumHold(b_q.regs[IDX_LOOP_HOLD][MIN_HOLD_MSB:0]),
        .discontinuous(discontinuousConduction),
        .phaseChanged(seqChanged),
        .feedbackOutside(feedbackOutside),
        .holdLoops(dcLoopHold)
    );

    assign regReadData = b_q.readData;
    assign regUnmapped = b_q.unmapped;
    assign rail1ReadyOutput = b_q.rail1Ready;
    assign rail2ReadyOutput = b_q.rail2Ready;
    assign phaseLevel = seqLevel;
    assign phaseLevelChanged = seqChanged;
    assign discontinuousConduction = (seqLevel == LEVEL_DCM);
    assign addLowIntervalInsert = b_q.lowInsert;
    assign droopNegative = b_q.regs[IDX_DROOP][DROOP_SIGN_BIT]; // R16
    assign droopMagnitude = b_q.regs[IDX_DROOP][DROOP_MAG_MSB:0]; // R16
    assign protocolRevisionCode = b_q.regs[IDX_PROTOCOL][7:0]; // R2
    assign telemetryCapability = b_q.regs[IDX_CAPABILITY][15:8]; // R3
    assign loadLineValue = b_q.regs[IDX_CAPABILITY][7:0]; // R4
    assign fastSlewCapability = b_q.regs[IDX_SLEW][15:8]; // R5
    assign slowSlewCapability = b_q.regs[IDX_SLEW][7:0]; // R5
    assign rail2ToleranceBand = b_q.regs[IDX_TOLERANCE][7:0]; // R8
endmodule
`default_nettype wire

// ===== rail2_shed_pkg.sv
// Constants, register map and types shared by the rail 2 shedding register bank
package rail2_shed_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned DROP_WAIT_STEP_US = 1;
    localparam int unsigned DROP_WAIT_STEP_CYCLES = (DROP_WAIT_STEP_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_STEP_US = 200;
    localparam int unsigned HOLD_OFFSET_US = 100;
    localparam int unsigned HOLD_STEP_CYCLES = (HOLD_STEP_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_OFFSET_CYCLES = (HOLD_OFFSET_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned PERIOD_STEP_NS = 80;

    localparam int unsigned REG_COUNT = 10;
    localparam int unsigned IDX_PROTOCOL = 0;
    localparam int unsigned IDX_CAPABILITY = 1;
    localparam int unsigned IDX_SLEW = 2;
    localparam int unsigned IDX_TOLERANCE = 3;
    localparam int unsigned IDX_THRESH_PAIR = 4;
    localparam int unsigned IDX_THRESH_SINGLE = 5;
    localparam int unsigned IDX_PACING = 6;
    localparam int unsigned IDX_DROOP = 7;
    localparam int unsigned IDX_LOOP_HOLD = 8;
    localparam int unsigned IDX_EXIT = 9;

    typedef logic [7:0] command_type;
    typedef logic [15:0] word_type;
    localparam command_type REG_COMMAND [REG_COUNT] = '{
        8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hc9, 8'hcb, 8'hcc};
    localparam word_type REG_WRITE_MASK [REG_COUNT] = '{
        16'h00ff, 16'hffff, 16'hffff, 16'h03ff, 16'hffff,
        16'h00ff, 16'h7f0f, 16'h003f, 16'hffff, 16'h0007};
    localparam word_type REG_RESET = 16'h0000;

    localparam int unsigned RAIL1_READY_BIT = 9;
    localparam int unsigned RAIL2_READY_BIT = 8;
    localparam int unsigned SHED_MODE_BIT = 8;
    localparam int unsigned DROP_WAIT_LSB = 9;
    localparam int unsigned DROP_WAIT_MSB = 14;
    localparam int unsigned HYS_MSB = 3;
    localparam int unsigned DROOP_SIGN_BIT = 5;
    localparam int unsigned DROOP_MAG_MSB = 4;
    localparam int unsigned PERIOD_ADD_BIT = 15;
    localparam int unsigned UNDERVOLT_ADD_BIT = 14;
    localparam int unsigned WINDOW_MSB = 13;
    localparam int unsigned WINDOW_LSB = 7;
    localparam int unsigned FREQ_HOLD_BIT = 6;
    localparam int unsigned PHASE_HOLD_BIT = 5;
    localparam int unsigned WINDOW_HOLD_BIT = 4;
    localparam int unsigned MIN_HOLD_MSB = 3;
    localparam int unsigned EXIT_OC_BIT = 0;
    localparam int unsigned EXIT_FS_BIT = 1;
    localparam int unsigned EXIT_UV_BIT = 2;
    localparam int unsigned APS_ENABLE_BIT = 1;

    typedef logic [1:0] phase_level_type;
    localparam phase_level_type LEVEL_DCM = 2'h0;
    localparam phase_level_type LEVEL_ONE = 2'h1;
    localparam phase_level_type LEVEL_TWO = 2'h2;
    localparam phase_level_type LEVEL_FULL = 2'h3;
endpackage

// ===== shed_phase_sequencer.sv
// Steps the rail 2 phase level toward its target, directly or one phase at a time
`timescale 1ns/100ps
`default_nettype none
module shed_phase_sequencer
    import rail2_shed_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire rail2_shed_pkg::phase_level_type targetLevel,
    input wire logic stepMode,
    input wire logic [5:0] waitSteps,
    output logic [1:0] phaseLevel,
    output logic levelChanged
);
    typedef enum logic [1:0] {SEQ_IDLE = 2'b01, SEQ_WAIT = 2'b10} seq_state_type;
    typedef struct packed {
        seq_state_type state;
        phase_level_type level;
        logic [5:0] stepCount;
        logic [7:0] cycleCount;
        logic changed;
    } seq_type;
    localparam logic [7:0] STEP_LAST = 8'(DROP_WAIT_STEP_CYCLES - 1);
    seq_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.changed = 1'b0;
        if (targetLevel > s_q.level) begin
            // Adding is never paced: load rises faster than a wait allows
            s_d.level = targetLevel;
            s_d.changed = 1'b1;
            s_d.state = SEQ_IDLE;
        end else if (targetLevel == s_q.level) begin
            s_d.state = SEQ_IDLE;
        end else if (!stepMode) begin
            s_d.level = targetLevel; // R13
            s_d.changed = 1'b1;
        end else begin
            unique case (s_q.state)
                SEQ_IDLE: begin
                    s_d.level = s_q.level - 2'h1; // R13
                    s_d.changed = 1'b1;
                    s_d.state = SEQ_WAIT;
                    s_d.stepCount = 6'h00;
                    s_d.cycleCount = 8'h00;
                end
                SEQ_WAIT: begin
                    if (s_q.stepCount == waitSteps) begin // R14
                        s_d.state = SEQ_IDLE;
                    end else if (s_q.cycleCount == STEP_LAST) begin
                        s_d.cycleCount = 8'h00;
                        s_d.stepCount = s_q.stepCount + 6'h01;
                    end else begin
                        s_d.cycleCount = s_q.cycleCount + 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '{state: SEQ_IDLE, level: LEVEL_FULL, stepCount: 6'h00, cycleCount: 8'h00, changed: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign phaseLevel = s_q.level;
    assign levelChanged = s_q.changed;
endmodule
`default_nettype wire

// ===== dc_loop_hold.sv
// Holds the DC and current-balance loops on enabled events for a minimum time
`timescale 1ns/100ps
`default_nettype none
module dc_loop_hold
    import rail2_shed_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = HOLD_STEP_CYCLES,
    parameter int unsigned OFFSET_CYCLES = HOLD_OFFSET_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] periodDeviationNs,
    input wire logic [6:0] deviationWindow,
    input wire logic frequencyEnable,
    input wire logic phaseEnable,
    input wire logic windowEnable,
    input wire logic [3:0] minimumHold,
    input wire logic discontinuous,
    input wire logic phaseChanged,
    input wire logic feedbackOutside,
    output logic holdLoops
);
    typedef struct packed {
        logic [19:0] count;
        logic hold;
    } hold_type;
    hold_type h_q, h_d;
    logic [15:0] windowNs;
    logic trigger;
    logic [19:0] loadCount;

    always_comb begin
        windowNs = 16'(deviationWindow) * 16'(PERIOD_STEP_NS);
        trigger = (frequencyEnable && !discontinuous && periodDeviationNs <= windowNs) // R19 R20
            || (phaseEnable && phaseChanged) || (windowEnable && feedbackOutside); // R20
        loadCount = 20'(OFFSET_CYCLES + STEP_CYCLES * minimumHold); // R21
        h_d = h_q;
        if (trigger) begin
            h_d.count = loadCount;
        end else if (h_q.count != 20'h0_0000) begin
            h_d.count = h_q.count - 20'h0_0001;
        end
        h_d.hold = trigger || (h_q.count != 20'h0_0000);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            h_q <= '{count: 20'h0_0000, hold: 1'b0};
        end else begin
            h_q <= h_d;
        end
    end

    assign holdLoops = h_q.hold;
endmodule
`default_nettype wire

// ===== rail2_serial_voltage_id_bus_phase_shed_config_assertions.sv
// Port-level checks for the rail 2 shedding register bank
`timescale 1ns/100ps
`default_nettype none
module rail2_shed_checker
    import rail2_shed_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic regRead,
    input wire rail2_shed_pkg::command_type regCommand,
    input wire rail2_shed_pkg::word_type regReadData,
    input wire logic regUnmapped,
    input wire logic [1:0] apsModeField,
    input wire logic rail1VoltageZero,
    input wire logic rail1PowerGood,
    input wire logic rail2VoltageZero,
    input wire logic rail2PowerGood,
    input wire logic rail1ReadyOutput,
    input wire logic rail2ReadyOutput,
    input wire logic [1:0] phaseLevel,
    input wire logic discontinuousConduction,
    input wire logic phaseLevelChanged
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence readOf(c);
        regRead && regCommand == c;
    endsequence
    sequence apsOffRun;
        !apsModeField[1] [*3];
    endsequence
    chk_unmapped_read: assert property (regRead && !(regCommand inside {REG_COMMAND})
        |=> regUnmapped && regReadData == 16'h0000)
        else $error("unmapped read");
    chk_protocol_high: assert property (readOf(8'hc1) |=> regReadData[15:8] == 8'h00)
        else $error("protocol high set");
    chk_droop_reserved: assert property (readOf(8'hc9) |=> regReadData[15:6] == 10'h000)
        else $error("droop reserved set");
    chk_pacing_reserved: assert property (readOf(8'hc7) |=> !regReadData[15] && regReadData[7:4] == 4'h0)
        else $error("pacing reserved set");
    chk_ready1_high: assert property (rail1PowerGood && !rail1VoltageZero |=> rail1ReadyOutput)
        else $error("rail 1 ready missing");
    chk_ready2_high: assert property (rail2PowerGood && !rail2VoltageZero |=> rail2ReadyOutput)
        else $error("rail 2 ready missing");
    chk_dcm_decode: assert property (discontinuousConduction == (phaseLevel == 2'h0))
        else $error("discontinuous flag wrong");
    chk_level_pulse: assert property (phaseLevel != $past(phaseLevel) |-> phaseLevelChanged)
        else $error("level without pulse");
    chk_aps_off_full: assert property (apsOffRun |-> phaseLevel == LEVEL_FULL)
        else $error("shed while off");
endmodule
`default_nettype wire

// ===== mgmt_host_model.sv
// Management host model driving the register strobe port
`timescale 1ns/100ps
`default_nettype none
module mgmt_host_model
    import rail2_shed_pkg::*;
(
    input wire logic clk,
    output logic regWrite,
    output logic regRead,
    output rail2_shed_pkg::command_type regCommand,
    output rail2_shed_pkg::word_type regWriteData,
    input wire rail2_shed_pkg::word_type regReadData,
    input wire logic regUnmapped
);
    initial {regWrite, regRead, regCommand, regWriteData} = 26'h000_0000;
    task automatic wr(input command_type cmd, input word_type data);
        @(posedge clk);
        regWrite <= 1'b1;
        regCommand <= cmd;
        regWriteData <= data;
        @(posedge clk);
        regWrite <= 1'b0;
        regCommand <= ~cmd;
        regWriteData <= ~data;
        #1;
    endtask
    task automatic rd(input command_type cmd, output word_type data, output logic unm);
        @(posedge clk);
        regRead <= 1'b1;
        regCommand <= cmd;
        @(posedge clk);
        regRead <= 1'b0;
        regCommand <= ~cmd;
        #1;
        data = regReadData;
        unm = regUnmapped;
    endtask
endmodule
`default_nettype wire

// ===== rail2_serial_voltage_id_bus_phase_shed_config_tb_top.sv
// Self-checking bench for the rail 2 shedding register bank
`timescale 1ns/100ps
`default_nettype none
module rail2_serial_voltage_id_bus_phase_shed_config_tb_top;
    import rail2_shed_pkg::*;
    localparam int unsigned STEP = 4, OFFS = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic regWrite, regRead, regUnmapped, rail1ReadyOutput, rail2ReadyOutput, dcLoopHold, droopNegative;
    logic discontinuousConduction, phaseLevelChanged, addLowIntervalInsert, u;
    command_type regCommand;
    word_type regWriteData, regReadData, d;
    logic [4:0] droopMagnitude;
    logic [7:0] protocolRevisionCode, telemetryCapability, loadLineValue, fastSlew, slowSlew, toleranceBand;
    logic [1:0] phaseLevel, apsModeField = 2'h0, voltageZero = 2'h3, powerGood = 2'h3;
    logic [7:0] railCurrent = 8'h00;
    logic [2:0] exitEvents = 3'h0;
    logic [15:0] periodDeviationNs = 16'hffff;
    logic feedbackOutside = 1'b0, periodAddRequest = 1'b0, undervoltageAddRequest = 1'b0;
    int bad_count = 0, comparisons = 0;
    initial forever #2 clk = ~clk;
    rail2_serial_voltage_id_bus_phase_shed_config #(.HOLD_STEP_CYCLE_COUNT(STEP), .HOLD_OFFSET_CYCLE_COUNT(OFFS)) dut_u (
        .clk, .rst, .regWrite, .regRead, .regCommand, .regWriteData, .regReadData, .regUnmapped,
        .apsModeField, .railCurrent, .overcurrentEvent(exitEvents[0]), .frequencyLimitEvent(exitEvents[1]),
        .lowFeedbackEvent(exitEvents[2]), .periodDeviationNs, .feedbackOutside, .periodAddRequest,
        .undervoltageAddRequest, .rail1VoltageZero(voltageZero[0]), .rail2VoltageZero(voltageZero[1]),
        .rail1PowerGood(powerGood[0]), .rail2PowerGood(powerGood[1]), .rail1ReadyOutput, .rail2ReadyOutput,
        .phaseLevel, .discontinuousConduction, .phaseLevelChanged, .dcLoopHold, .addLowIntervalInsert,
        .droopNegative, .droopMagnitude, .protocolRevisionCode, .telemetryCapability, .loadLineValue,
        .fastSlewCapability(fastSlew), .slowSlewCapability(slowSlew), .rail2ToleranceBand(toleranceBand));
    mgmt_host_model host_u (.clk, .regWrite, .regRead, .regCommand, .regWriteData, .regReadData, .regUnmapped);
    task automatic chk(input word_type seen, input word_type exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t saw %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic goCur(input logic [7:0] v, input phase_level_type lv);
        int n = 0;
        @(posedge clk);
        railCurrent <= v;
        exitEvents <= 3'h0;
        while (phaseLevel !== lv && n < 2000) begin
            tick(1);
            n++;
        end
        chk(word_type'(phaseLevel), word_type'(lv));
        if (n == 2000) print_verdict();
    endtask
    task automatic s_regs();
        for (int i = 0; i < 10; i++) begin
            host_u.rd(REG_COMMAND[i], d, u);
            chk(d, 16'h0000);
            host_u.wr(REG_COMMAND[i], 16'hffff);
            host_u.rd(REG_COMMAND[i], d, u);
            chk(d, REG_WRITE_MASK[i]);
        end
        host_u.rd(8'hc8, d, u);
        chk({d[15:1], u}, 16'h0001);
        for (int c = 1; c <= 8; c++) begin
            host_u.wr(8'hc1, word_type'(c));
            chk(word_type'(protocolRevisionCode), word_type'(c));
        end
        host_u.wr(8'hc2, 16'ha55a);
        chk({telemetryCapability, loadLineValue}, 16'ha55a);
        host_u.wr(8'hc3, 16'h3c12);
        chk({fastSlew, slowSlew}, 16'h3c12);
        host_u.wr(8'hc4, 16'hfc77);
        chk(word_type'(toleranceBand), 16'h0077);
        host_u.wr(8'hc9, 16'h00f5);
        chk(word_type'({droopNegative, droopMagnitude}), 16'h0035);
    endtask
    task automatic s_ready();
        for (int p = 0; p < 4; p++) begin
            host_u.wr(8'hc4, word_type'(p) << 8);
            tick(2);
            chk(word_type'({rail1ReadyOutput, rail2ReadyOutput}), word_type'({p[1], p[0]}));
        end
        @(posedge clk);
        voltageZero <= 2'h0;
        tick(2);
        chk(word_type'({rail1ReadyOutput, rail2ReadyOutput}), 16'h0003);
    endtask
    task automatic s_shed();
        host_u.wr(8'hc6, 16'h0005);
        host_u.wr(8'hc5, 16'h0a14);
        host_u.wr(8'hc7, 16'h0004);
        @(posedge clk);
        apsModeField <= 2'h2;
        goCur(8'h03, LEVEL_DCM);
        goCur(8'h0c, LEVEL_ONE);
        goCur(8'h11, LEVEL_TWO);
        @(posedge clk);
        railCurrent <= 8'h17;
        tick(8);
        chk(word_type'(phaseLevel), 16'h0002);
        goCur(8'h18, LEVEL_FULL);
        @(posedge clk);
        railCurrent <= 8'h00;
        tick(4);
        chk(word_type'(phaseLevel), 16'h0000);
    endtask
    task automatic s_paced();
        int n;
        host_u.wr(8'hc7, 16'h0300);
        goCur(8'h1e, LEVEL_FULL);
        @(posedge clk);
        railCurrent <= 8'h00;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                tick(1);
                n++;
            end while (phaseLevelChanged !== 1'b1 && n < 600);
            chk(word_type'(phaseLevel), word_type'(2 - k));
            if (k > 0) chk(word_type'(n >= 250 && n <= 256), 16'h0001);
            if (n == 600) print_verdict();
        end
    endtask
    task automatic s_exit();
        host_u.wr(8'hc7, 16'h0000);
        for (int e = 0; e < 6; e++) begin
            host_u.wr(8'hcc, (e < 3) ? 16'h0007 : 16'h0000);
            @(posedge clk);
            exitEvents <= 3'(1 << (e % 3));
            tick(4);
            chk(word_type'(phaseLevel), (e < 3) ? 16'h0003 : 16'h0000);
            goCur(8'h00, LEVEL_DCM);
        end
    endtask
    task automatic holdRun(input word_type cb, input logic [15:0] dev, input logic fb, input int exp);
        int n = 0;
        host_u.wr(8'hcb, cb);
        @(posedge clk);
        periodDeviationNs <= dev;
        feedbackOutside <= fb;
        @(posedge clk);
        periodDeviationNs <= 16'hffff;
        feedbackOutside <= 1'b0;
        repeat (40) begin
            #1;
            if (dcLoopHold === 1'b1) n++;
            @(posedge clk);
        end
        chk(word_type'(n), word_type'(exp));
    endtask
    task automatic s_hold();
        @(posedge clk);
        apsModeField <= 2'h0;
        tick(80);
        holdRun(16'h0011, 16'hffff, 1'b1, OFFS + STEP + 1);
        holdRun(16'h0001, 16'hffff, 1'b1, 0);
        holdRun(16'h00c0, 16'h0050, 1'b0, OFFS + 1);
        holdRun(16'h00c0, 16'h0051, 1'b0, 0);
        holdRun(16'h0047, 16'h0000, 1'b0, OFFS + 7 * STEP + 1);
        @(posedge clk);
        apsModeField <= 2'h3;
        goCur(8'h00, LEVEL_DCM);
        holdRun(16'h00c0, 16'h0050, 1'b0, 0);
    endtask
    task automatic s_add();
        for (int i = 0; i < 4; i++) begin
            host_u.wr(8'hcb, word_type'(i) << 14);
            @(posedge clk);
            periodAddRequest <= 1'b1;
            @(posedge clk);
            periodAddRequest <= 1'b0;
            #1;
            chk(word_type'(addLowIntervalInsert), word_type'(!i[1]));
            @(posedge clk);
            undervoltageAddRequest <= 1'b1;
            @(posedge clk);
            undervoltageAddRequest <= 1'b0;
            #1;
            chk(word_type'(addLowIntervalInsert), word_type'(!i[0]));
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        s_regs();
        s_ready();
        s_shed();
        s_paced();
        s_exit();
        s_hold();
        s_add();
        print_verdict();
    end
endmodule
bind rail2_serial_voltage_id_bus_phase_shed_config rail2_shed_checker chk_u (.clk, .rst, .regRead, .regCommand, .regReadData,
    .regUnmapped, .apsModeField, .rail1VoltageZero, .rail1PowerGood, .rail2VoltageZero, .rail2PowerGood,
    .rail1ReadyOutput, .rail2ReadyOutput, .phaseLevel, .discontinuousConduction, .phaseLevelChanged);
`default_nettype wire
